// [common/abu_defines.svh]
// Register offsets, field positions, reset values and constants of the breakpoint unit
`ifndef ABU_DEFINES_SVH
`define ABU_DEFINES_SVH
`define ABU_OFF_CTRL      12'h000
`define ABU_OFF_ADDRH     12'h004
`define ABU_OFF_ADDRL     12'h008
`define ABU_OFF_AUX       12'h00C
`define ABU_OFF_WAITST    12'h010
`define ABU_OFF_FLAGCTL   12'h014
`define ABU_OFF_IRQSTAT   12'h018
`define ABU_OFF_IRQMASK   12'h01C
`define ABU_BIT_ENABLE    7
`define ABU_BIT_ACTIVE    6
`define ABU_BIT_WDSUP     7
`define ABU_BIT_WAITEXIT  1
`define ABU_BIT_FLAGCLR   7
`define ABU_BIT_EV_MATCH  0
`define ABU_BIT_EV_SOFT   1
`define ABU_BIT_EV_END    2
`define ABU_RST_BYTE      8'h00
`define ABU_OPC_SWI       8'h83
`define ABU_OPC_RTI       8'h80
`define ABU_VEC_NORMAL    16'hFFFC
`define ABU_VEC_MONITOR   16'hFEFC
`endif

// [common/abu_pkg.sv]
// Types shared by the breakpoint unit
package abu_pkg;
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic        opcodeFetch;
    logic        instrBoundary;
  } abu_cpu_t;
  typedef struct packed {
    logic       accept;
    logic       rtiDone;
    logic       waitMode;
    logic       stopMode;
    logic       monitorMode;
  } abu_sys_t;
  typedef enum logic [2:0] {
    ABU_IDLE    = 3'b001,
    ABU_PENDING = 3'b010,
    ABU_BREAK   = 3'b100
  } abu_state_t;
endpackage : abu_pkg

// [logic/abu_match_reg.sv]
`timescale 1ns/10ps
// Registered 16-bit address comparator gated by a sample strobe
module abu_match_reg (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [15:0] breakAddr,
  input  wire logic [15:0] busAddr,
  input  wire logic        sample,
  output logic             hit
);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hit <= 1'b0;
    end else begin
      hit <= sample && (busAddr == breakAddr);
    end
  end
endmodule : abu_match_reg

// [logic/address_breakpoint_unit.sv]
`timescale 1ns/10ps
// Address breakpoint unit with APB register slave
`include "abu_defines.svh"

module address_breakpoint_unit (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire abu_pkg::abu_cpu_t cpu,
  input  wire abu_pkg::abu_sys_t sys,
  output logic                  breakpointRequest,
  output logic                  forceSwiOpcode,
  output logic      [7:0]       opcodeOverride,
  output logic      [15:0]      breakVector,
  output logic                  breakActiveState,
  output logic                  timerHalt,
  output logic                  watchdogSuppress,
  output logic                  flagClearAllowed,
  output logic                  irq
);
  abu_pkg::abu_state_t state;
  logic [7:0]  breakAddrHigh;
  logic [7:0]  breakAddrLow;
  logic        breakEnable;
  logic        breakActive;
  logic        wdSuppressBit;
  logic        flagClearBit;
  logic        waitExitFlag;
  logic [2:0]  irqStatus;
  logic [2:0]  irqMask;
  logic        matchHit;
  logic        matchArmed;
  logic        softRequest;
  logic        breakPending;
  logic        breakStart;
  logic        breakEnd;
  logic [15:0] lastBreakAddr;

  function automatic logic abuSel(input logic [11:0] a, input logic [11:0] off);
    abuSel = (a == off);
  endfunction : abuSel

  logic        apbWrite;
  logic        apbRead;
  logic        wrByte0;
  assign apbWrite = psel && penable && pwrite;
  assign apbRead  = psel && penable && !pwrite;
  assign wrByte0  = apbWrite && pstrb[0];
  assign pready   = 1'b1;

  logic mapped;
  always_comb begin
    mapped = abuSel(paddr, `ABU_OFF_CTRL) || abuSel(paddr, `ABU_OFF_ADDRH) ||
             abuSel(paddr, `ABU_OFF_ADDRL) || abuSel(paddr, `ABU_OFF_AUX) ||
             abuSel(paddr, `ABU_OFF_WAITST) || abuSel(paddr, `ABU_OFF_FLAGCTL) ||
             abuSel(paddr, `ABU_OFF_IRQSTAT) || abuSel(paddr, `ABU_OFF_IRQMASK);
  end
  assign pslverr = psel && penable && !mapped;

  // Match sampled only on live opcode fetches, never in wait or stop
  logic sampleMatch;
  assign sampleMatch = breakEnable && cpu.valid && cpu.opcodeFetch && matchArmed &&
                       !sys.waitMode && !sys.stopMode && (state == abu_pkg::ABU_IDLE);

  abu_match_reg u_match (
    .clk       (clk),
    .arst_n    (arst_n),
    .breakAddr ({breakAddrHigh, breakAddrLow}),
    .busAddr   (cpu.addr),
    .sample    (sampleMatch),
    .hit       (matchHit)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      breakAddrHigh <= `ABU_RST_BYTE;
      breakAddrLow  <= `ABU_RST_BYTE;
    end else begin
      if (wrByte0 && abuSel(paddr, `ABU_OFF_ADDRH)) begin
        breakAddrHigh <= pwdata[7:0];
      end
      if (wrByte0 && abuSel(paddr, `ABU_OFF_ADDRL)) begin
        breakAddrLow <= pwdata[7:0];
      end
    end
  end

  // Enable bit written through bit 7 of control
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      breakEnable <= 1'b0;
    end else if (wrByte0 && abuSel(paddr, `ABU_OFF_CTRL)) begin
      breakEnable <= pwdata[`ABU_BIT_ENABLE];
    end
  end

  // Active bit: match sets and wins over a write of zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      breakActive <= 1'b0;
    end else if (matchHit) begin
      breakActive <= 1'b1;
    end else if (wrByte0 && abuSel(paddr, `ABU_OFF_CTRL)) begin
      breakActive <= pwdata[`ABU_BIT_ACTIVE];
    end
  end

  // Software write of one requests a break
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      softRequest <= 1'b0;
    end else if (wrByte0 && abuSel(paddr, `ABU_OFF_CTRL) && pwdata[`ABU_BIT_ACTIVE] &&
                 (state == abu_pkg::ABU_IDLE)) begin
      softRequest <= 1'b1;
    end else if (breakStart) begin
      softRequest <= 1'b0;
    end
  end

  // Address that caused the last break stays disarmed until changed or until a break ends with the active bit set
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lastBreakAddr <= 16'h0000;
      matchArmed    <= 1'b1;
    end else if (matchHit) begin
      lastBreakAddr <= {breakAddrHigh, breakAddrLow};
      matchArmed    <= 1'b0;
    end else if (!matchArmed && (lastBreakAddr != {breakAddrHigh, breakAddrLow})) begin
      matchArmed <= 1'b1;
    end else if (!matchArmed && breakEnd && breakActive) begin
      matchArmed <= 1'b1;
    end
  end

  // Auxiliary and flag control registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wdSuppressBit <= 1'b0;
      flagClearBit  <= 1'b0;
    end else begin
      if (wrByte0 && abuSel(paddr, `ABU_OFF_AUX)) begin
        wdSuppressBit <= pwdata[`ABU_BIT_WDSUP];
      end
      if (wrByte0 && abuSel(paddr, `ABU_OFF_FLAGCTL)) begin
        flagClearBit <= pwdata[`ABU_BIT_FLAGCLR];
      end
    end
  end

  // Request held from match until accepted at a boundary
  assign breakPending = matchHit || softRequest || (state == abu_pkg::ABU_PENDING);
  assign breakStart   = (state == abu_pkg::ABU_PENDING) && sys.accept;
  // Return from interrupt closes the break
  assign breakEnd     = (state == abu_pkg::ABU_BREAK) && sys.rtiDone;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= abu_pkg::ABU_IDLE;
    end else begin
      case (state)
        abu_pkg::ABU_IDLE: begin
          if (breakPending) begin
            state <= abu_pkg::ABU_PENDING;
          end
        end
        abu_pkg::ABU_PENDING: begin
          if (sys.accept) begin
            state <= abu_pkg::ABU_BREAK;
          end
        end
        abu_pkg::ABU_BREAK: begin
          if (sys.rtiDone) begin
            state <= abu_pkg::ABU_IDLE;
          end
        end
        default: begin
          state <= abu_pkg::ABU_IDLE;
        end
      endcase
    end
  end

  // Request waits for the instruction boundary from the core
  assign breakpointRequest = (state == abu_pkg::ABU_PENDING);

  // Swap in the software interrupt opcode at break start
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      forceSwiOpcode <= 1'b0;
      opcodeOverride <= `ABU_RST_BYTE;
    end else begin
      forceSwiOpcode <= breakStart;
      opcodeOverride <= breakStart ? `ABU_OPC_SWI : `ABU_RST_BYTE;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      breakVector <= `ABU_VEC_NORMAL;
    end else if (breakStart) begin
      breakVector <= sys.monitorMode ? `ABU_VEC_MONITOR : `ABU_VEC_NORMAL;
    end
  end

  // Set when a break ends wait mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      waitExitFlag <= 1'b0;
    end else if (breakStart && sys.waitMode) begin
      waitExitFlag <= 1'b1;
    end else if (breakStart) begin
      waitExitFlag <= 1'b0;
    end
  end

  assign breakActiveState = (state == abu_pkg::ABU_BREAK);
  // Timer halted while the break runs
  assign timerHalt        = breakActiveState;
  // Watchdog held off in a monitor-mode break
  assign watchdogSuppress = breakActiveState && sys.monitorMode && wdSuppressBit;
  // During a break, other modules may clear flags only with permission
  assign flagClearAllowed = !breakActiveState || flagClearBit;

  // Interrupt status: events set, read clears, set wins
  logic [2:0] events;
  logic       statusRead;
  assign events     = {breakEnd, softRequest && breakStart, matchHit};
  assign statusRead = apbRead && abuSel(paddr, `ABU_OFF_IRQSTAT);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqStatus <= 3'h0;
    end else if (statusRead) begin
      irqStatus <= events;
    end else begin
      irqStatus <= irqStatus | events;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqMask <= 3'h0;
    end else if (wrByte0 && abuSel(paddr, `ABU_OFF_IRQMASK)) begin
      irqMask <= pwdata[2:0];
    end
  end

  assign irq = |(irqStatus & irqMask);

  // Read data registered on the setup phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `ABU_OFF_CTRL:    prdata <= {24'h000000, breakEnable, breakActive, 6'h00};
        `ABU_OFF_ADDRH:   prdata <= {24'h000000, breakAddrHigh};
        `ABU_OFF_ADDRL:   prdata <= {24'h000000, breakAddrLow};
        `ABU_OFF_AUX:     prdata <= {24'h000000, wdSuppressBit, 7'h00};
        `ABU_OFF_WAITST:  prdata <= {30'h00000000, waitExitFlag, 1'b0};
        `ABU_OFF_FLAGCTL: prdata <= {24'h000000, flagClearBit, 7'h00};
        `ABU_OFF_IRQSTAT: prdata <= {29'h00000000, irqStatus};
        `ABU_OFF_IRQMASK: prdata <= {29'h00000000, irqMask};
        default:          prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : address_breakpoint_unit

// [tb/abu_assertions.sv]
// Port assertions of the breakpoint unit
`timescale 1ns/10ps
`include "abu_defines.svh"
module abu_checker (
  input wire logic              clk,
  input wire logic              arst_n,
  input wire abu_pkg::abu_sys_t sys,
  input wire logic              breakpointRequest,
  input wire logic              forceSwiOpcode,
  input wire logic [7:0]        opcodeOverride,
  input wire logic [15:0]       breakVector,
  input wire logic              breakActiveState,
  input wire logic              timerHalt,
  input wire logic              watchdogSuppress,
  input wire logic              flagClearAllowed
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  req_held_a: assert property (breakpointRequest && !sys.accept |=> breakpointRequest)
    else $error("request dropped");
  swi_load_a: assert property (breakpointRequest && sys.accept |=>
    forceSwiOpcode && opcodeOverride == `ABU_OPC_SWI ##1 !forceSwiOpcode) else $error("no swi load");
  opc_idle_a: assert property (!forceSwiOpcode |-> opcodeOverride == 8'h00)
    else $error("stray opcode");
  vec_select_a: assert property (breakpointRequest && sys.accept |=> breakVector ==
    ($past(sys.monitorMode) ? `ABU_VEC_MONITOR : `ABU_VEC_NORMAL)) else $error("bad vector");
  break_enter_a: assert property (breakpointRequest && sys.accept |=> breakActiveState)
    else $error("break not entered");
  rti_end_a: assert property (breakActiveState && sys.rtiDone |=> !breakActiveState)
    else $error("break not ended");
  timer_halt_a: assert property (timerHalt == breakActiveState)
    else $error("timer halt wrong");
  wd_gate_a: assert property (watchdogSuppress |-> breakActiveState && sys.monitorMode)
    else $error("watchdog gate wrong");
  flag_free_a: assert property (!breakActiveState |-> flagClearAllowed)
    else $error("flag clear blocked");
endmodule : abu_checker
bind address_breakpoint_unit abu_checker chk (.clk(clk), .arst_n(arst_n), .sys(sys),
  .breakpointRequest(breakpointRequest), .forceSwiOpcode(forceSwiOpcode), .opcodeOverride(opcodeOverride),
  .breakVector(breakVector), .breakActiveState(breakActiveState), .timerHalt(timerHalt),
  .watchdogSuppress(watchdogSuppress), .flagClearAllowed(flagClearAllowed));

// [tb/abu_core_model.sv]
// Behavioural core and integration logic at the unit's far side
`timescale 1ns/10ps
module abu_core_model (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         run,
  input  wire logic [3:0]   acceptDelay,
  input  wire logic         doRti,
  input  wire logic         monitor,
  input  wire logic         waitMode,
  input  wire logic         breakpointRequest,
  input  wire logic         breakActiveState,
  output abu_pkg::abu_cpu_t cpu,
  output abu_pkg::abu_sys_t sys
);
  logic [15:0] pc;
  logic [3:0]  cnt;
  logic        accept, rtiDone, fetch;
  assign fetch = run && !breakActiveState && !waitMode;
  // Released bus shows the inverted address
  assign cpu = '{fetch, fetch ? pc : ~pc, fetch && !pc[0], !pc[0]};
  assign sys = '{accept, rtiDone, waitMode, 1'b0, monitor};
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc <= 16'h0000;
      cnt <= 4'h0;
      accept <= 1'b0;
      rtiDone <= 1'b0;
    end else begin
      pc <= !run ? 16'h1230 : (fetch && !(breakpointRequest && !pc[0])) ? pc + 16'h0001 : pc;
      cnt <= (breakpointRequest && !accept) ? cnt + 4'h1 : 4'h0;
      accept <= breakpointRequest && !accept && !pc[0] && cnt >= acceptDelay;
      rtiDone <= doRti && breakActiveState && !rtiDone;
    end
  end
endmodule : abu_core_model

// [tb/address_breakpoint_unit_test.sv]
// Self-checking bench for the breakpoint unit
`timescale 1ns/10ps
`include "abu_defines.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; $display("Error %0t: got %h want %h", $time, g, e); end end
module address_breakpoint_unit_test;
  logic              clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic              run = 1'b0, doRti = 1'b0, mon = 1'b0, waitMd = 1'b0, err;
  logic              pready, pslverr, bpReq, forceSwi, brk, tHalt, wdSup, flagOk, irq;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h00000000, prdata;
  logic [15:0]       vec;
  logic [7:0]        opc, q;
  logic [3:0]        dly = 4'h0;
  abu_pkg::abu_cpu_t cpu;
  abu_pkg::abu_sys_t sys;
  int                n_errors = 0, samples_checked = 0;
  initial forever #5 clk = ~clk;
  address_breakpoint_unit dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu(cpu), .sys(sys), .breakpointRequest(bpReq), .forceSwiOpcode(forceSwi), .opcodeOverride(opc),
    .breakVector(vec), .breakActiveState(brk), .timerHalt(tHalt), .watchdogSuppress(wdSup),
    .flagClearAllowed(flagOk), .irq(irq));
  abu_core_model core (.clk(clk), .arst_n(arst_n), .run(run), .acceptDelay(dly), .doRti(doRti),
    .monitor(mon), .waitMode(waitMd), .breakpointRequest(bpReq), .breakActiveState(brk), .cpu(cpu), .sys(sys));
  task automatic test_done;
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic fail;
    $display("Error %0t: timeout", $time);
    n_errors++;
    test_done();
  endtask : fail
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      fail();
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    `CHK(q, e)
  endtask : rd
  task automatic waitBrk(input logic v);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (brk !== v && n < 40);
    if (n >= 40)
      fail();
  endtask : waitBrk
  task automatic go(input logic r, input logic t);
    @(posedge clk);
    run <= r;
    doRti <= t;
  endtask : go
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 8; i++)
      rd(12'(4 * i), 8'h00);
    rd(12'h020, 8'h00);
    `CHK(err, 1'b1)
    `CHK(flagOk, 1'b1)
    `CHK(vec, `ABU_VEC_NORMAL)
    wr(`ABU_OFF_ADDRH, 8'h12);
    wr(`ABU_OFF_ADDRL, 8'h34);
    wr(`ABU_OFF_AUX, 8'h80);
    wr(`ABU_OFF_CTRL, 8'h80);
    rd(`ABU_OFF_ADDRH, 8'h12);
    rd(`ABU_OFF_CTRL, 8'h80);
    go(1'b1, 1'b0);
    waitBrk(1'b1);
    `CHK(tHalt, 1'b1)
    `CHK(wdSup, 1'b0)
    `CHK(flagOk, 1'b0)
    `CHK(irq, 1'b0)
    rd(`ABU_OFF_CTRL, 8'hC0);
    rd(`ABU_OFF_WAITST, 8'h00);
    wr(`ABU_OFF_IRQMASK, 8'h01);
    #1 `CHK(irq, 1'b1)
    rd(`ABU_OFF_IRQSTAT, 8'h01);
    #1 `CHK(irq, 1'b0)
    wr(`ABU_OFF_FLAGCTL, 8'h80);
    #1 `CHK(flagOk, 1'b1)
    wr(`ABU_OFF_FLAGCTL, 8'h00);
    wr(`ABU_OFF_CTRL, 8'h80);
    rd(`ABU_OFF_CTRL, 8'h80);
    go(1'b0, 1'b1);
    waitBrk(1'b0);
    rd(`ABU_OFF_IRQSTAT, 8'h04);
    go(1'b1, 1'b0);
    repeat (20) @(posedge clk);
    #1 `CHK(brk, 1'b0)
    go(1'b0, 1'b0);
    wr(`ABU_OFF_ADDRL, 8'h38);
    dly <= 4'h6;
    go(1'b1, 1'b0);
    waitBrk(1'b1);
    wr(`ABU_OFF_CTRL, 8'h00);
    go(1'b0, 1'b1);
    waitBrk(1'b0);
    rd(`ABU_OFF_IRQSTAT, 8'h05);
    @(posedge clk);
    mon <= 1'b1;
    waitMd <= 1'b1;
    dly <= 4'h0;
    doRti <= 1'b0;
    wr(`ABU_OFF_CTRL, 8'h40);
    waitBrk(1'b1);
    `CHK(vec, `ABU_VEC_MONITOR)
    `CHK(wdSup, 1'b1)
    rd(`ABU_OFF_WAITST, 8'h02);
    rd(`ABU_OFF_IRQSTAT, 8'h02);
    go(1'b0, 1'b1);
    waitBrk(1'b0);
    `CHK(wdSup, 1'b0)
    test_done();
  end
endmodule : address_breakpoint_unit_test
